// file: tfcs_pkg.sv
// constants and types for the fabric-transceiver clock select block
// Contract
// (RULE_01) tx data sampled on tx FIFO write clock
// (RULE_02) tx write clock automatic unless user clock enabled
// (RULE_03) non-bonded: tx parallel clock writes tx FIFO
// (RULE_04) bonded: common bonded clock writes tx FIFO
// (RULE_05) user tx clock has zero offset
// (RULE_06) rx data launched on rx FIFO read clock
// (RULE_07) rx read clock automatic unless user clock enabled
// (RULE_08) non-bonded rate match: tx clock reads rx FIFO
// (RULE_09) no rate match: recovered clock reads and writes
// (RULE_10) bonded rate match: bonded clock reads rx FIFO
// (RULE_11) user rx clock has zero offset
// (RULE_12) rate match only in transmit-and-receive operation
// (RULE_13) fabric gives receiver-detect clock in PIPE mode
// (RULE_14) export FIFO clocks, accept reconfig and cal clocks
// (RULE_15) offset cancellation timed by reconfiguration clock
// (RULE_16) reconfiguration clock free-running, not transceiver-derived
// (RULE_17) calibration clock at most stated frequency
// (RULE_18) one cal clock and power-down for all
// (RULE_19) cal power-down release restarts calibration
// (RULE_20) bonded byte serializer halves tx read clock
// (RULE_21) clock selection frozen while data passes
package tfcs_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CAL = 8'h08;
    // control register fields
    localparam int CTRL_BONDED = 0;
    localparam int CTRL_RATE_MATCH = 1;
    localparam int CTRL_USER_TX_CLK = 2;
    localparam int CTRL_USER_RX_CLK = 3;
    localparam int CTRL_BYTE_SER = 4;
    localparam int CTRL_MODE_LSB = 5;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // calibration register fields
    localparam int CAL_POWERDOWN = 0;
    localparam int CAL_OC_START = 1;
    localparam logic CAL_POWERDOWN_RESET = 1'b1;
    // status register fields
    localparam int STAT_TX_WR_SEL_LSB = 0;
    localparam int STAT_RX_RD_SEL_LSB = 2;
    localparam int STAT_RATE_MATCH = 4;
    localparam int STAT_BONDED = 5;
    localparam int STAT_CAL_BUSY = 6;
    localparam int STAT_CAL_DONE = 7;
    localparam int STAT_OC_BUSY = 8;
    localparam int STAT_OC_DONE = 9;
    localparam int STAT_CFG_LOCKED = 10;
    // sequence lengths, counted in edges of their own clocks
    localparam int CAL_STEPS = 16;
    localparam int OC_STEPS = 32;
    // clock source codes
    typedef enum logic [1:0] {
        SRC_TX_LOWSPEED = 2'b00,
        SRC_BONDED = 2'b01,
        SRC_RX_RECOVERED = 2'b10,
        SRC_USER = 2'b11
    } tfcs_src_t;
    // channel operation
    typedef enum logic [1:0] {
        MODE_TXRX = 2'b00,
        MODE_TX_ONLY = 2'b01,
        MODE_RX_ONLY = 2'b10
    } tfcs_mode_t;
    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN = 2'b01,
        SEQ_DONE = 2'b10
    } tfcs_seq_t;
endpackage : tfcs_pkg

// file: tfcs_step_seq.sv
// step sequencer timed by rising edges of a slow sampled clock
`timescale 1ns/1ps
module tfcs_step_seq
    import tfcs_pkg::*;
#(
    parameter int STEPS = 16
)
(
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic start,
    input wire logic hold,
    input wire logic tick_lvl,
    // status
    output logic busy,
    output logic done
);
    tfcs_seq_t state;
    logic tick_prev;
    logic [$clog2(STEPS+1)-1:0] cnt;
    logic tick_rise;

    // edge of the timing clock
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tick_prev <= 1'b0;
        else
            tick_prev <= tick_lvl;
    end
    assign tick_rise = tick_lvl & ~tick_prev;

    // state: hold parks it, start begins again from step zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state <= SEQ_IDLE;
        else if (hold)
            state <= SEQ_IDLE;
        else if (start)
            state <= SEQ_RUN;
        else if (state == SEQ_RUN && tick_rise
                 && cnt == ($clog2(STEPS+1))'(STEPS - 1))
            state <= SEQ_DONE;
    end

    // step counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt <= '0;
        else if (hold || start)
            cnt <= '0;
        else if (state == SEQ_RUN && tick_rise)
            cnt <= cnt + 1'b1;
    end

    assign busy = (state == SEQ_RUN);
    assign done = (state == SEQ_DONE);
endmodule : tfcs_step_seq

// file: tfcs_top.sv
// fabric-transceiver clock select with AHB-Lite control registers
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tfcs_top
    import tfcs_pkg::*;
#(
    parameter int DW = 16
)
(
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // clock sources from the channel, sampled as levels
    input wire logic tx_lowspeed_clk,
    input wire logic bonded_clk,
    input wire logic rx_recovered_clk,
    // clocks from the fabric
    input wire logic user_tx_wr_clk,
    input wire logic user_rx_rd_clk,
    input wire logic reconfig_clk,
    input wire logic cal_clk,
    input wire logic rx_detect_clk,
    // channel status
    input wire logic data_active,
    input wire logic power_cycle,
    // selected FIFO clocks
    output logic tx_fifo_wr_clk,
    output logic tx_fifo_rd_clk,
    output logic rx_fifo_wr_clk,
    output logic rx_fifo_rd_clk,
    // clocks exported to the fabric
    output logic tx_clkout,
    output logic rx_clkout,
    output logic bonded_clkout,
    output logic rx_detect_clk_out,
    // shared calibration controls
    output logic cal_clk_out,
    output logic cal_powerdown_out,
    // data at the fabric boundary
    input wire logic [DW-1:0] tx_data_in,
    output logic [DW-1:0] tx_fifo_data,
    input wire logic [DW-1:0] rx_fifo_data,
    output logic [DW-1:0] rx_data_out
);
    // pick one clock level by source code
    function automatic logic pick_clk(input tfcs_src_t sel, input logic [3:0] srcs);
        pick_clk = srcs[sel];
    endfunction : pick_clk

    logic [6:0] ctrl;
    logic cal_pd;
    logic cal_pd_prev;
    logic oc_kick;
    logic oc_first;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    tfcs_mode_t mode;
    logic eff_bonded;
    logic eff_rate_match;
    tfcs_src_t tx_wr_sel;
    tfcs_src_t rx_rd_sel;
    tfcs_src_t rx_wr_sel;
    logic [3:0] clk_srcs;
    logic div_clk;
    logic bonded_prev;
    logic tx_wr_prev;
    logic rx_rd_prev;
    logic next_tx_wr;
    logic next_tx_rd;
    logic next_rx_wr;
    logic next_rx_rd;
    logic cal_busy;
    logic cal_done;
    logic oc_busy;
    logic oc_done;
    logic [31:0] status;
    logic wr_ctrl;
    logic wr_cal;

    // address phase capture, zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end
        else if (hready)
        begin
            ap_valid <= hsel & htrans[1];
            ap_write <= hwrite;
            ap_addr <= haddr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_ctrl = ap_valid & ap_write & (ap_addr == ADDR_CTRL);
    assign wr_cal = ap_valid & ap_write & (ap_addr == ADDR_CAL);

    // control register, ignored while the channel passes data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl <= CTRL_RESET;
        else if (wr_ctrl && !data_active) // RULE_21
            ctrl <= hwdata[6:0];
    end

    // calibration power-down, one bit shared by all channels
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cal_pd <= CAL_POWERDOWN_RESET;
            cal_pd_prev <= CAL_POWERDOWN_RESET;
        end
        else
        begin
            if (wr_cal)
                cal_pd <= hwdata[CAL_POWERDOWN]; // RULE_18
            cal_pd_prev <= cal_pd;
        end
    end

    // offset cancellation kick: after reset, power cycle or software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            oc_first <= 1'b1;
        else
            oc_first <= 1'b0;
    end
    assign oc_kick = oc_first | power_cycle | (wr_cal & hwdata[CAL_OC_START]);

    // effective configuration
    assign mode = tfcs_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
    assign eff_bonded = ctrl[CTRL_BONDED] & (mode != MODE_RX_ONLY);
    assign eff_rate_match = ctrl[CTRL_RATE_MATCH] & (mode == MODE_TXRX); // RULE_12

    // tx FIFO write clock source
    always_comb
    begin
        if (ctrl[CTRL_USER_TX_CLK])
            tx_wr_sel = SRC_USER; // RULE_02
        else if (eff_bonded)
            tx_wr_sel = SRC_BONDED; // RULE_04
        else
            tx_wr_sel = SRC_TX_LOWSPEED; // RULE_03
    end

    // rx FIFO write clock source
    always_comb
    begin
        if (!eff_rate_match)
            rx_wr_sel = SRC_RX_RECOVERED; // RULE_09
        else if (eff_bonded)
            rx_wr_sel = SRC_BONDED;
        else
            rx_wr_sel = SRC_TX_LOWSPEED;
    end

    // rx FIFO read clock source
    always_comb
    begin
        if (ctrl[CTRL_USER_RX_CLK])
            rx_rd_sel = SRC_USER; // RULE_07
        else if (!eff_rate_match)
            rx_rd_sel = SRC_RX_RECOVERED; // RULE_09
        else if (eff_bonded)
            rx_rd_sel = SRC_BONDED; // RULE_10
        else
            rx_rd_sel = SRC_TX_LOWSPEED; // RULE_08
    end

    // halved bonded clock for the byte serializer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bonded_prev <= 1'b0;
            div_clk <= 1'b0;
        end
        else
        begin
            bonded_prev <= bonded_clk;
            if (bonded_clk && !bonded_prev)
                div_clk <= ~div_clk; // RULE_20
        end
    end

    // source vector, index by code; the user slot is tied low, user clocks are muxed per use
    assign clk_srcs = {1'b0, rx_recovered_clk, bonded_clk, tx_lowspeed_clk};

    // next FIFO clock levels
    always_comb
    begin
        next_tx_wr = (tx_wr_sel == SRC_USER) ? user_tx_wr_clk
                                             : pick_clk(tx_wr_sel, clk_srcs);
        next_rx_rd = (rx_rd_sel == SRC_USER) ? user_rx_rd_clk
                                             : pick_clk(rx_rd_sel, clk_srcs);
        next_rx_wr = pick_clk(rx_wr_sel, clk_srcs);
        if (eff_bonded)
            next_tx_rd = ctrl[CTRL_BYTE_SER] ? div_clk : bonded_clk; // RULE_20
        else
            next_tx_rd = tx_lowspeed_clk;
    end

    // registered clock outputs and exports
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_fifo_wr_clk <= 1'b0;
            tx_fifo_rd_clk <= 1'b0;
            rx_fifo_wr_clk <= 1'b0;
            rx_fifo_rd_clk <= 1'b0;
            tx_clkout <= 1'b0;
            rx_clkout <= 1'b0;
            bonded_clkout <= 1'b0;
            rx_detect_clk_out <= 1'b0;
            cal_clk_out <= 1'b0;
            cal_powerdown_out <= CAL_POWERDOWN_RESET;
        end
        else
        begin
            tx_fifo_wr_clk <= next_tx_wr;
            tx_fifo_rd_clk <= next_tx_rd;
            rx_fifo_wr_clk <= next_rx_wr;
            rx_fifo_rd_clk <= next_rx_rd;
            tx_clkout <= tx_lowspeed_clk; // RULE_14
            rx_clkout <= rx_recovered_clk; // RULE_14
            bonded_clkout <= bonded_clk; // RULE_14
            rx_detect_clk_out <= rx_detect_clk;
            cal_clk_out <= cal_clk; // RULE_18
            cal_powerdown_out <= cal_pd; // RULE_18
        end
    end

    // data sampled and launched on the FIFO clock edges
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_wr_prev <= 1'b0;
            rx_rd_prev <= 1'b0;
            tx_fifo_data <= '0;
            rx_data_out <= '0;
        end
        else
        begin
            tx_wr_prev <= next_tx_wr;
            rx_rd_prev <= next_rx_rd;
            if (next_tx_wr && !tx_wr_prev)
                tx_fifo_data <= tx_data_in; // RULE_01
            if (next_rx_rd && !rx_rd_prev)
                rx_data_out <= rx_fifo_data; // RULE_06
        end
    end

    // calibration restarts on release of power-down
    tfcs_step_seq #(.STEPS(CAL_STEPS)) u_cal_seq (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(cal_pd_prev & ~cal_pd), // RULE_19
        .hold(cal_pd),
        .tick_lvl(cal_clk),
        .busy(cal_busy),
        .done(cal_done)
    );

    // offset cancellation stepped by the reconfiguration clock
    tfcs_step_seq #(.STEPS(OC_STEPS)) u_oc_seq (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(oc_kick),
        .hold(1'b0),
        .tick_lvl(reconfig_clk), // RULE_15
        .busy(oc_busy),
        .done(oc_done)
    );

    // status word
    always_comb
    begin
        status = 32'h0000_0000;
        status[STAT_TX_WR_SEL_LSB +: 2] = tx_wr_sel;
        status[STAT_RX_RD_SEL_LSB +: 2] = rx_rd_sel;
        status[STAT_RATE_MATCH] = eff_rate_match;
        status[STAT_BONDED] = eff_bonded;
        status[STAT_CAL_BUSY] = cal_busy;
        status[STAT_CAL_DONE] = cal_done;
        status[STAT_OC_BUSY] = oc_busy;
        status[STAT_OC_DONE] = oc_done;
        status[STAT_CFG_LOCKED] = data_active;
    end

    // read data mux, unmapped reads as zero
    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (ap_valid && !ap_write)
        begin
            unique case (ap_addr)
                ADDR_CTRL: hrdata = {25'h0, ctrl};
                ADDR_STATUS: hrdata = status;
                ADDR_CAL: hrdata = {31'h0, cal_pd};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end
endmodule : tfcs_top

// file: tfcs_checker.sv
// assertion checker for the clock select block
`timescale 1ns/1ps
module tfcs_checker
    import tfcs_pkg::*;
#(parameter int DW = 16)
(
    // bus side
    input wire logic hclk, hresetn, hsel, hwrite, hready,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [31:0] hwdata,
    // clocks
    input wire logic tx_lowspeed_clk, bonded_clk, rx_recovered_clk,
    input wire logic user_tx_wr_clk, user_rx_rd_clk, cal_clk, data_active,
    input wire logic tx_fifo_wr_clk, tx_fifo_rd_clk, rx_fifo_wr_clk,
    input wire logic rx_fifo_rd_clk, tx_clkout, rx_clkout, bonded_clkout,
    input wire logic cal_clk_out, cal_powerdown_out,
    input wire logic rx_detect_clk, rx_detect_clk_out,
    // data
    input wire logic [DW-1:0] tx_data_in, tx_fifo_data, rx_fifo_data, rx_data_out
);
    logic [7:0] wa;
    logic wv, pd, bnd, rm, xw, rw, rr, tr;
    logic [6:0] ctrl;
    logic [1:0] up;
    // address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wv <= 1'b0;
            wa <= 8'h00;
        end
        else if (hready)
        begin
            wv <= hsel && htrans[1] && hwrite;
            wa <= haddr;
        end
    end
    // shadow of control and calibration writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl <= CTRL_RESET;
            pd <= CAL_POWERDOWN_RESET;
        end
        else if (wv && hready)
        begin
            if (wa == ADDR_CTRL && !data_active)
                ctrl <= hwdata[6:0];
            if (wa == ADDR_CAL)
                pd <= hwdata[CAL_POWERDOWN];
        end
    end
    // cycles since reset release
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            up <= 2'h0;
        else if (up != 2'h3)
            up <= up + 2'h1;
    end
    // expected sources
    assign bnd = ctrl[0] && ctrl[6:5] != 2'h2;
    assign rm = ctrl[1] && ctrl[6:5] == 2'h0;
    assign xw = ctrl[2] ? user_tx_wr_clk : (bnd ? bonded_clk : tx_lowspeed_clk);
    assign rw = !rm ? rx_recovered_clk : (bnd ? bonded_clk : tx_lowspeed_clk);
    assign rr = ctrl[3] ? user_rx_rd_clk : rw;
    assign tr = bnd ? bonded_clk : tx_lowspeed_clk;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_tx_wr_sel: assert property (up == 2'h3 |-> tx_fifo_wr_clk == $past(xw))
        else $error("tx fifo write clock from wrong source");
    a_rx_wr_sel: assert property (up == 2'h3 |-> rx_fifo_wr_clk == $past(rw))
        else $error("rx fifo write clock from wrong source");
    a_rx_rd_sel: assert property (up == 2'h3 |-> rx_fifo_rd_clk == $past(rr))
        else $error("rx fifo read clock from wrong source");
    a_tx_rd_sel: assert property (up == 2'h3 && !$past(ctrl[4] && bnd)
        |-> tx_fifo_rd_clk == $past(tr))
        else $error("tx fifo read clock from wrong source");
    a_clk_export: assert property (up == 2'h3 |-> {tx_clkout, rx_clkout, bonded_clkout,
        cal_clk_out, rx_detect_clk_out}
        == $past({tx_lowspeed_clk, rx_recovered_clk, bonded_clk, cal_clk, rx_detect_clk}))
        else $error("exported clocks wrong");
    a_tx_capture: assert property ($rose(tx_fifo_wr_clk)
        |-> tx_fifo_data == $past(tx_data_in))
        else $error("tx data not taken on write clock");
    a_rx_launch: assert property ($rose(rx_fifo_rd_clk)
        |-> rx_data_out == $past(rx_fifo_data))
        else $error("rx data not launched on read clock");
    a_cal_pd: assert property (pd == $past(pd) |-> cal_powerdown_out == pd)
        else $error("calibration power-down output wrong");
    // main scenarios
    cover property (rm && bnd);
    cover property (ctrl[2] && ctrl[3]);
    cover property ($fell(pd));
endmodule : tfcs_checker

bind tfcs_top tfcs_checker #(.DW(DW)) tfcs_checker_i (.*);

// file: tfcs_fabric_model.sv
// fabric side model: user clocks, calibration clocks and tx data
`timescale 1ns/1ps
module tfcs_fabric_model
    import tfcs_pkg::*;
#(parameter int DW = 16)
(
    // system
    input wire logic hclk,
    input wire logic tx_clkout,
    // clocks into the block
    output logic user_tx_wr_clk = 1'b0,
    output logic user_rx_rd_clk = 1'b0,
    output logic reconfig_clk = 1'b0,
    output logic cal_clk = 1'b0,
    output logic rx_detect_clk = 1'b0,
    // transmit data
    output logic [DW-1:0] tx_data_in = '0
);
    logic [2:0] cnt = 3'h0;
    logic last = 1'b0;
    // free-running dividers; user and cal clocks at the channel low-speed clock rate, reconfig half, rx detect twice
    always @(posedge hclk)
    begin
        cnt <= cnt + 3'h1;
        user_tx_wr_clk <= ~cnt[1];
        user_rx_rd_clk <= ~cnt[1];
        reconfig_clk <= cnt[2];
        cal_clk <= cnt[1];
        rx_detect_clk <= cnt[0];
    end
    // next tx word launched as tx_clkout falls
    always @(posedge hclk)
    begin
        last <= tx_clkout;
        if (last && !tx_clkout)
            tx_data_in <= DW'(tx_data_in + 1);
    end
endmodule : tfcs_fabric_model

// file: test_transceiver_fabric_clock_select.sv
// self-checking bench for the clock select block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module test_transceiver_fabric_clock_select
    import tfcs_pkg::*;
();
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic data_active = 1'b0, power_cycle = 1'b0, ok;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic [3:0] tc = 4'h0;
    logic [15:0] rxd = 16'h0;
    wire hreadyout, hresp, utx, urx, rcf, calc, rdet, txo, txr;
    wire [15:0] txd;
    int bad_count = 0, comparisons = 0;
    logic [6:0] cfg [10] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h08, 7'h0C, 7'h22,
        7'h43, 7'h41};
    tfcs_top tfcs_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .tx_lowspeed_clk(tc[1]), .bonded_clk(tc[2]), .rx_recovered_clk(tc[3]),
        .user_tx_wr_clk(utx), .user_rx_rd_clk(urx), .reconfig_clk(rcf), .cal_clk(calc),
        .rx_detect_clk(rdet), .data_active(data_active), .power_cycle(power_cycle),
        .tx_fifo_wr_clk(), .tx_fifo_rd_clk(txr), .rx_fifo_wr_clk(), .rx_fifo_rd_clk(),
        .tx_clkout(txo), .rx_clkout(), .bonded_clkout(), .rx_detect_clk_out(),
        .cal_clk_out(), .cal_powerdown_out(), .tx_data_in(txd), .tx_fifo_data(),
        .rx_fifo_data(rxd), .rx_data_out());
    tfcs_fabric_model tfcs_fabric_model_i (.hclk(hclk), .tx_clkout(txo),
        .user_tx_wr_clk(utx), .user_rx_rd_clk(urx), .reconfig_clk(rcf), .cal_clk(calc),
        .rx_detect_clk(rdet), .tx_data_in(txd));
    // clock
    initial forever #2.5 hclk = ~hclk;
    // channel clocks and rx fifo words
    always @(posedge hclk)
    begin
        tc <= tc + 4'h1;
        rxd <= rxd + 16'h1;
    end
    // one single bus transfer
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    // read status until a bit is set
    task automatic poll(input int b);
        ok = 1'b0;
        for (int i = 0; i < 300 && !ok; i++)
        begin
            xfer(ADDR_STATUS, 1'b0, 32'h0, rd);
            ok = rd[b];
        end
    endtask : poll
    function automatic logic [5:0] exp_stat(input logic [6:0] c);
        logic b, m;
        b = c[0] && c[6:5] != 2'h2;
        m = c[1] && c[6:5] == 2'h0;
        return {b, m, c[3] ? 2'h3 : (!m ? 2'h2 : {1'b0, b}), c[2] ? 2'h3 : {1'b0, b}};
    endfunction : exp_stat
    task automatic t_regs;
        xfer(ADDR_CTRL, 1'b0, 32'h0, rd);
        `CHK("ctrl reset", 32'h0, rd)
        xfer(ADDR_CAL, 1'b0, 32'h0, rd);
        `CHK("cal reset", 32'h1, rd)
        xfer(8'h0C, 1'b1, 32'hFF, rd);
        xfer(8'h0C, 1'b0, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        `CHK("okay response", 1'b0, hresp)
        $display("test regs done");
    endtask : t_regs
    task automatic t_select;
        foreach (cfg[i])
        begin
            xfer(ADDR_CTRL, 1'b1, {25'h0, cfg[i]}, rd);
            repeat (20) @(posedge hclk);
            xfer(ADDR_STATUS, 1'b0, 32'h0, rd);
            `CHK("status sel", exp_stat(cfg[i]), rd[5:0])
        end
        $display("test select done");
    endtask : t_select
    task automatic t_freeze;
        xfer(ADDR_CTRL, 1'b1, 32'h1, rd);
        data_active <= 1'b1;
        xfer(ADDR_CTRL, 1'b1, 32'h2, rd);
        xfer(ADDR_CTRL, 1'b0, 32'h0, rd);
        `CHK("frozen ctrl", 32'h1, rd)
        xfer(ADDR_STATUS, 1'b0, 32'h0, rd);
        `CHK("cfg locked", 1'b1, rd[STAT_CFG_LOCKED])
        data_active <= 1'b0;
        $display("test freeze done");
    endtask : t_freeze
    task automatic t_bser;
        int n;
        logic p;
        n = 0;
        p = 1'b1;
        xfer(ADDR_CTRL, 1'b1, 32'h11, rd);
        repeat (128)
        begin
            @(posedge hclk);
            if (txr && !p)
                n++;
            p = txr;
        end
        `CHK("halved edges", 1'b1, n >= 7 && n <= 9)
        xfer(ADDR_CTRL, 1'b1, 32'h0, rd);
        $display("test byte serializer done");
    endtask : t_bser
    task automatic t_cal;
        xfer(ADDR_CAL, 1'b1, 32'h0, rd);
        poll(STAT_CAL_DONE);
        `CHK("cal done", 1'b1, ok)
        xfer(ADDR_CAL, 1'b1, 32'h1, rd);
        xfer(ADDR_STATUS, 1'b0, 32'h0, rd);
        `CHK("cal idle", 2'h0, rd[7:6])
        xfer(ADDR_CAL, 1'b1, 32'h0, rd);
        xfer(ADDR_STATUS, 1'b0, 32'h0, rd);
        `CHK("cal restart", 2'h1, rd[7:6])
        $display("test calibration done");
    endtask : t_cal
    task automatic t_oc;
        xfer(ADDR_CAL, 1'b1, 32'h2, rd);
        xfer(ADDR_STATUS, 1'b0, 32'h0, rd);
        `CHK("oc busy", 2'h1, rd[9:8])
        poll(STAT_OC_DONE);
        `CHK("oc done", 1'b1, ok)
        power_cycle <= 1'b1;
        @(posedge hclk);
        power_cycle <= 1'b0;
        xfer(ADDR_STATUS, 1'b0, 32'h0, rd);
        `CHK("oc rerun", 2'h1, rd[9:8])
        poll(STAT_OC_DONE);
        `CHK("oc done again", 1'b1, ok)
        $display("test offset cancellation done");
    endtask : t_oc
    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // watchdog
    initial
    begin
        repeat (8000) @(posedge hclk);
        bad_count++;
        wrap_up();
    end
    // main sequence
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_select();
        t_freeze();
        t_bser();
        t_cal();
        t_oc();
        wrap_up();
    end
endmodule : test_transceiver_fabric_clock_select
